// file: inc/fcc_cfg.svh
// Register map, field positions, reset values and timing counts
`ifndef FCC_CFG_SVH
`define FCC_CFG_SVH
`define FCC_CLK_MHZ        125
`define FCC_OFS_CTRL       8'h00
`define FCC_OFS_STATUS     8'h04
`define FCC_OFS_RCCNT      8'h08
`define FCC_CTRL_RATE_1G   0
`define FCC_CTRL_PATTERN   1
`define FCC_CTRL_RESTART   2
`define FCC_CTRL_AUTOLOCK  3
`define FCC_CTRL_TRAIN_PLL 4
`define FCC_CTRL_RST       5'h18
`define FCC_PLL_PD_NS      1000
`define FCC_RX_DLY_NS      4000
`define FCC_PLL_PD_CYC     ((`FCC_PLL_PD_NS * `FCC_CLK_MHZ + 999) / 1000)
`define FCC_RX_DLY_CYC     ((`FCC_RX_DLY_NS * `FCC_CLK_MHZ + 999) / 1000)
`define FCC_PATTERN        40'hAAAAAAAAAA
`define FCC_BYTE_K28_5     8'hBC
`define FCC_BYTE_D21_4     8'h95
`define FCC_BYTE_D21_5     8'hB5
`define FCC_BYTE_D21_3     8'h75
`define FCC_COMMA_NEG      7'h7C
`define FCC_COMMA_POS      7'h03
`define FCC_ES_DEPTH       4
`define FCC_ES_HI          3'h3
`endif

// file: inc/fcc_pkg.sv
// Types shared by the fibre channel coding block
package fcc_pkg;
	typedef logic [9:0] fcc_sym_t;
	typedef enum logic [2:0]
	{
		FCC_RST_PLLPD    = 3'h0,
		FCC_RST_WAIT_PLL = 3'h1,
		FCC_RST_WAIT_CDR = 3'h2,
		FCC_RST_RX_DLY   = 3'h3,
		FCC_RST_RUN      = 3'h4
	} fcc_rst_e;
endpackage

// file: inc/fcc_sym_if.sv
// One encoder lane: byte in, ten-bit symbol and disparity out
`timescale 1ns/100ps
interface fcc_sym_if;
	import fcc_pkg::*;
	logic     [7:0] byte_val;
	logic           k;
	logic           rd_in;
	fcc_sym_t       sym;
	logic           rd_out;
	modport enc (input byte_val, input k, input rd_in,
		output sym, output rd_out);
	modport user (output byte_val, output k, output rd_in,
		input sym, input rd_out);
endinterface

// file: rtl/fcc_enc.sv
// Combinational 8b/10b encoder for one symbol with disparity in and out
`timescale 1ns/100ps
module fcc_enc
	import fcc_pkg::*;
(
	fcc_sym_if.enc p
);
	localparam logic [5:0] C6 [0:31] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] C4 [0:7] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
	localparam logic [5:0] K28_6B = 6'h0F;
	localparam logic [5:0] D7_6B  = 6'h38;
	localparam logic [3:0] X3_4B  = 4'hC;
	localparam logic [3:0] A7_4B  = 4'h7;

	logic [4:0] x;
	logic [2:0] y;
	logic [5:0] c6;
	logic [3:0] c4;
	logic       bal6;
	logic       bal4;
	logic       rd_mid;
	logic       alt7;

	// Only K28.y control symbols are produced; K with another x acts as K28
	always_comb
	begin
		x = p.byte_val[4:0];
		y = p.byte_val[7:5];
		c6 = p.k ? K28_6B : C6[x];
		bal6 = ($countones(c6) == 3);
		if (p.rd_in && (!bal6 || c6 == D7_6B))
			c6 = ~c6;
		rd_mid = bal6 ? p.rd_in : ~p.rd_in;
		c4 = C4[y];
		alt7 = p.k
			|| (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd_mid && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
		if (y == 3'h7 && alt7)
			c4 = A7_4B;
		bal4 = ($countones(c4) == 2);
		if (rd_mid && (!bal4 || c4 == X3_4B))
			c4 = ~c4;
		else if (!rd_mid && p.k && bal4 && c4 != X3_4B)
			c4 = ~c4;
		// Bit 0 of the symbol is bit a, the first on the line
		p.sym = {<<{c6, c4}};
		p.rd_out = bal4 ? rd_mid : ~rd_mid; // [R17]
	end
endmodule

// file: rtl/fcc_top.sv
// One fibre channel lane: bus slave, reset sequence, coder, rate matcher
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "fcc_cfg.svh"
// Contract
// [R1] EOF variant follows preceding word's ending disparity
// [R2] Transceiver gives no disparity; fabric derives it
// [R3] 8b/10b encoding done here, transceiver coder bypassed
// [R4] Link needs 8b/10b plus clock rate compensation
// [R5] Fabric provides the clock rate compensation
// [R6] Parallel path is 20 or 40 bits
// [R7] Receive words split into whole 10-bit symbols
// [R8] Lane uses only its own link clocks
// [R9] Independent coding and attachment resets per lane
// [R10] Reset sequence drives PLL power-down
// [R11] Two PLLs per group, two transmit rates
// [R12] Transmit clock from PLL, receive from recovery
// [R13] Recovery unit may train from PLL reference
// [R14] Transmit can send 1010 test pattern
// [R15] Users wait for PLL lock before sending
// [R16] Frequency lock loss holds receive logic reset
// [R17] Disparity starts negative, updated per symbol
// [R18] Fill words inserted or deleted between frames only
module fcc_top
	import fcc_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        tx_clkout,
	input  wire logic [31:0] tx_user_data,
	input  wire logic [3:0]  tx_user_k,
	input  wire logic        tx_user_eof,
	output logic             tx_user_ready,
	output logic             tx_user_take,
	output logic      [39:0] tx_parallel_data,
	input  wire logic        rx_clkout,
	input  wire logic [39:0] rx_parallel_data,
	output logic      [39:0] rx_user_data,
	output logic      [3:0]  rx_user_comma,
	output logic             rx_user_valid,
	input  wire logic        pll_locked,
	input  wire logic        rx_freqlocked,
	output logic             pll_powerdown,
	output logic             tx_digitalreset,
	output logic             rx_analogreset,
	output logic             rx_digitalreset,
	output logic             rx_cdr_train_pll
);
	logic [4:0]  ctrl_reg;
	logic        restart_reg;
	logic        wr_pend_reg;
	logic [7:0]  wr_addr_reg;
	logic        ahb_go;
	logic [31:0] rd_mux;
	logic [15:0] ins_cnt_reg;
	logic [15:0] del_cnt_reg;
	logic        cnt_clr;
	logic        ins_ev;
	logic        del_ev;

	logic [2:0]  tx_sync_reg;
	logic [2:0]  rx_sync_reg;
	logic [1:0]  pll_sync_reg;
	logic [1:0]  frq_sync_reg;
	logic [39:0] rxd_s1_reg;
	logic [39:0] rxd_s2_reg;
	logic        tx_edge;
	logic        rx_fall;
	logic        pll_lk;
	logic        frq_lk;
	logic        rate_1g;
	logic        autolock;

	fcc_rst_e    st_reg;
	fcc_rst_e    st_next;
	logic [15:0] st_cnt_reg;

	logic        rd_reg;
	logic        eof_tail_reg;
	logic [31:0] enc_byte;
	logic [3:0]  enc_k;
	logic [39:0] enc_sym;
	logic [3:0]  lane_rd;
	logic        word_rd;

	logic [39:0] es_mem [0:`FCC_ES_DEPTH-1];
	logic [2:0]  es_wp_reg;
	logic [2:0]  es_rp_reg;
	logic [2:0]  es_level;
	logic [39:0] rx_word;
	logic [39:0] last_w_reg;
	logic [39:0] last_o_reg;
	logic        last_o_fill_reg;
	logic        rx_drop;
	logic        es_push;
	logic        es_pop;

	function automatic logic is_comma(input logic [9:0] s);
		return s[6:0] == `FCC_COMMA_NEG || s[6:0] == `FCC_COMMA_POS;
	endfunction

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rate_1g = ctrl_reg[`FCC_CTRL_RATE_1G];
	assign autolock = ctrl_reg[`FCC_CTRL_AUTOLOCK];
	assign rx_cdr_train_pll = ctrl_reg[`FCC_CTRL_TRAIN_PLL]; // [R13]
	assign ahb_go = hsel && htrans[1] && hready;
	assign cnt_clr = wr_pend_reg && wr_addr_reg == `FCC_OFS_RCCNT;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else
		begin
			wr_pend_reg <= ahb_go && hwrite;
			if (ahb_go)
				wr_addr_reg <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= `FCC_CTRL_RST;
			restart_reg <= 1'b0;
		end
		else
		begin
			restart_reg <= 1'b0;
			if (wr_pend_reg && wr_addr_reg == `FCC_OFS_CTRL)
			begin
				ctrl_reg <= hwdata[4:0] & ~(5'h01 << `FCC_CTRL_RESTART);
				restart_reg <= hwdata[`FCC_CTRL_RESTART];
			end
		end
	end

	always_comb
	begin
		unique case (haddr[7:0])
			`FCC_OFS_CTRL:   rd_mux = {27'h0000000, ctrl_reg};
			`FCC_OFS_STATUS: rd_mux = {25'h0000000, st_reg, tx_user_ready,
				rd_reg, frq_lk, pll_lk};
			`FCC_OFS_RCCNT:  rd_mux = {del_cnt_reg, ins_cnt_reg};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= 32'h00000000;
		else if (ahb_go && !hwrite)
			hrdata <= rd_mux;
	end

	// A clear in the same cycle as an event leaves the count at one
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ins_cnt_reg <= 16'h0000;
			del_cnt_reg <= 16'h0000;
		end
		else
		begin
			ins_cnt_reg <= (cnt_clr ? 16'h0000 : ins_cnt_reg) + {15'h0000, ins_ev};
			del_cnt_reg <= (cnt_clr ? 16'h0000 : del_cnt_reg) + {15'h0000, del_ev};
		end
	end

	// Link clocks and lock levels are sampled twice before use
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			tx_sync_reg <= 3'h0;
			rx_sync_reg <= 3'h0;
			pll_sync_reg <= 2'h0;
			frq_sync_reg <= 2'h0;
			rxd_s1_reg <= 40'h0000000000;
			rxd_s2_reg <= 40'h0000000000;
		end
		else
		begin
			tx_sync_reg <= {tx_sync_reg[1:0], tx_clkout}; // [R8] [R12]
			rx_sync_reg <= {rx_sync_reg[1:0], rx_clkout}; // [R8] [R12]
			pll_sync_reg <= {pll_sync_reg[0], pll_locked};
			frq_sync_reg <= {frq_sync_reg[0], rx_freqlocked};
			rxd_s1_reg <= rx_parallel_data;
			rxd_s2_reg <= rxd_s1_reg;
		end
	end

	assign tx_edge = tx_sync_reg[1] && !tx_sync_reg[2];
	// Receive data is taken mid-period, away from its launch edge
	assign rx_fall = !rx_sync_reg[1] && rx_sync_reg[2];
	assign pll_lk = pll_sync_reg[1];
	assign frq_lk = frq_sync_reg[1];

	always_comb
	begin
		st_next = st_reg;
		unique case (st_reg)
			FCC_RST_PLLPD:
				if (st_cnt_reg == 16'(`FCC_PLL_PD_CYC - 1))
					st_next = FCC_RST_WAIT_PLL;
			FCC_RST_WAIT_PLL:
				if (pll_lk)
					st_next = FCC_RST_WAIT_CDR;
			FCC_RST_WAIT_CDR:
				if (frq_lk || !autolock)
					st_next = FCC_RST_RX_DLY;
			FCC_RST_RX_DLY:
				if (autolock && !frq_lk)
					st_next = FCC_RST_WAIT_CDR; // [R16]
				else if (st_cnt_reg == 16'(`FCC_RX_DLY_CYC - 1))
					st_next = FCC_RST_RUN;
			FCC_RST_RUN:
				if (autolock && !frq_lk)
					st_next = FCC_RST_WAIT_CDR; // [R16]
			default:
				st_next = FCC_RST_PLLPD;
		endcase
		if (restart_reg)
			st_next = FCC_RST_PLLPD;
		else if (!pll_lk && st_reg != FCC_RST_PLLPD)
			st_next = FCC_RST_WAIT_PLL;
	end

	// Each lane owns its own sequencer; lanes sharing a PLL tie power-downs
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_reg <= FCC_RST_PLLPD;
			st_cnt_reg <= 16'h0000;
			pll_powerdown <= 1'b1;
			tx_digitalreset <= 1'b1;
			rx_analogreset <= 1'b1;
			rx_digitalreset <= 1'b1;
		end
		else
		begin
			st_reg <= st_next;
			st_cnt_reg <= (st_next != st_reg) ? 16'h0000 : st_cnt_reg + 16'h0001;
			pll_powerdown <= st_next == FCC_RST_PLLPD; // [R10] [R11]
			tx_digitalreset <= st_next == FCC_RST_PLLPD
				|| st_next == FCC_RST_WAIT_PLL; // [R9]
			rx_analogreset <= st_next == FCC_RST_PLLPD
				|| st_next == FCC_RST_WAIT_PLL; // [R9]
			rx_digitalreset <= st_next != FCC_RST_RUN; // [R9] [R16]
		end
	end

	assign tx_user_ready = !tx_digitalreset && pll_lk; // [R15]

	always_comb
	begin
		enc_byte = tx_user_data;
		enc_k = tx_user_k;
		if (eof_tail_reg)
		begin
			enc_byte = {4{`FCC_BYTE_D21_3}};
			enc_k = 4'h0;
		end
		else if (tx_user_eof)
		begin
			enc_byte = {`FCC_BYTE_D21_3, `FCC_BYTE_D21_3,
				rd_reg ? `FCC_BYTE_D21_5 : `FCC_BYTE_D21_4,
				`FCC_BYTE_K28_5}; // [R1] [R2]
			enc_k = 4'h1;
		end
	end

	genvar gi;
	for (gi = 0; gi < 4; gi++)
	begin : g_lane
		fcc_sym_if lane ();
		fcc_enc u_enc
		(
			.p (lane.enc)
		); // [R3]
		assign lane.byte_val = enc_byte[gi*8 +: 8];
		assign lane.k = enc_k[gi];
		assign enc_sym[gi*10 +: 10] = lane.sym;
		assign lane_rd[gi] = lane.rd_out;
		if (gi == 0)
		begin : g_first
			assign lane.rd_in = rd_reg;
		end
		else
		begin : g_next
			assign lane.rd_in = lane_rd[gi-1]; // [R17]
		end
	end

	assign word_rd = rate_1g ? lane_rd[3] : lane_rd[1];

	// The word leaves a few cycles after the rising link edge it follows
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_reg <= 1'b0;
			eof_tail_reg <= 1'b0;
			tx_parallel_data <= 40'h0000000000;
			tx_user_take <= 1'b0;
		end
		else
		begin
			tx_user_take <= 1'b0;
			if (tx_digitalreset)
			begin
				rd_reg <= 1'b0; // [R17]
				eof_tail_reg <= 1'b0;
				tx_parallel_data <= 40'h0000000000;
			end
			else if (tx_edge && ctrl_reg[`FCC_CTRL_PATTERN])
				tx_parallel_data <= `FCC_PATTERN; // [R14]
			else if (tx_edge)
			begin
				rd_reg <= word_rd; // [R17]
				tx_parallel_data <= rate_1g ? enc_sym
					: {20'h00000, enc_sym[19:0]}; // [R6]
				eof_tail_reg <= !rate_1g && tx_user_eof && !eof_tail_reg;
				tx_user_take <= !eof_tail_reg;
			end
		end
	end

	assign rx_word = rate_1g ? rxd_s2_reg
		: {20'h00000, rxd_s2_reg[19:0]}; // [R6]
	assign es_level = es_wp_reg - es_rp_reg;
	// A repeat of the last ordered set is a fill and may be dropped
	assign rx_drop = is_comma(rx_word[9:0]) && rx_word == last_w_reg
		&& es_level >= `FCC_ES_HI; // [R18]
	assign es_push = rx_fall && !rx_digitalreset && !rx_drop
		&& es_level != 3'(`FCC_ES_DEPTH); // [R5]
	assign es_pop = tx_edge && !rx_digitalreset && es_level != 3'h0;
	assign del_ev = rx_fall && !rx_digitalreset && rx_drop;
	assign ins_ev = tx_edge && !rx_digitalreset && es_level == 3'h0
		&& last_o_fill_reg; // [R18]

	always_ff @(posedge hclk)
	begin
		if (es_push)
			es_mem[es_wp_reg[1:0]] <= rx_word;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			es_wp_reg <= 3'h0;
			es_rp_reg <= 3'h0;
			last_w_reg <= 40'h0000000000;
		end
		else if (rx_digitalreset)
		begin
			es_wp_reg <= 3'h0;
			es_rp_reg <= 3'h0;
			last_w_reg <= 40'h0000000000;
		end
		else
		begin
			if (es_push)
				es_wp_reg <= es_wp_reg + 3'h1; // [R4]
			if (rx_fall)
				last_w_reg <= rx_word;
			if (es_pop)
				es_rp_reg <= es_rp_reg + 3'h1;
		end
	end

	// Symbols are already on 10-bit boundaries, so lanes are plain slices
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_user_data <= 40'h0000000000;
			rx_user_comma <= 4'h0;
			rx_user_valid <= 1'b0;
			last_o_reg <= 40'h0000000000;
			last_o_fill_reg <= 1'b0;
		end
		else
		begin
			rx_user_valid <= es_pop || ins_ev;
			if (rx_digitalreset)
				last_o_fill_reg <= 1'b0;
			else if (es_pop)
			begin
				rx_user_data <= es_mem[es_rp_reg[1:0]];
				for (int i = 0; i < 4; i++)
					rx_user_comma[i] <= is_comma(es_mem[es_rp_reg[1:0]][i*10 +: 10]); // [R7]
				last_o_reg <= es_mem[es_rp_reg[1:0]];
				last_o_fill_reg <= is_comma(es_mem[es_rp_reg[1:0]][9:0])
					&& es_mem[es_rp_reg[1:0]] == last_o_reg;
			end
			else if (ins_ev)
			begin
				rx_user_data <= last_o_reg; // [R5] [R18]
				for (int i = 0; i < 4; i++)
					rx_user_comma[i] <= is_comma(last_o_reg[i*10 +: 10]);
			end
		end
	end
endmodule

// file: tb/fcc_top_properties.sv
// Concurrent checks on the lane's reset sequence and data ports
`timescale 1ns/100ps
`include "fcc_cfg.svh"
module fcc_top_properties
(
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        pll_locked,
	input wire logic        rx_freqlocked,
	input wire logic        pll_powerdown,
	input wire logic        tx_digitalreset,
	input wire logic        rx_analogreset,
	input wire logic        rx_digitalreset,
	input wire logic        rx_cdr_train_pll,
	input wire logic        tx_user_ready,
	input wire logic        tx_user_take,
	input wire logic [39:0] tx_parallel_data,
	input wire logic [39:0] rx_user_data,
	input wire logic [3:0]  rx_user_comma,
	input wire logic        rx_user_valid
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	function automatic logic comma_of(input logic [9:0] s);
		return s[6:0] == `FCC_COMMA_NEG || s[6:0] == `FCC_COMMA_POS;
	endfunction
	AST_PLLPD_HOLD: assert property (
		$rose(hresetn) |-> (pll_powerdown && rx_cdr_train_pll)[*8])
		else $error("pll power-down released too early");
	AST_PD_ORDER: assert property (
		pll_powerdown |-> tx_digitalreset && rx_analogreset && rx_digitalreset)
		else $error("lane reset released while pll powered down");
	AST_TXRST_LOCK: assert property (
		!pll_locked [*5] |-> tx_digitalreset)
		else $error("transmit reset not asserted after lock loss");
	AST_TXREADY: assert property (
		tx_user_ready |-> !tx_digitalreset && $past(pll_locked, 2))
		else $error("transmit ready without lock");
	AST_TXZERO: assert property (
		tx_digitalreset [*2] |-> tx_parallel_data == 40'h0 && !tx_user_take)
		else $error("transmit word active in reset");
	AST_TAKE_GAP: assert property (
		tx_user_take |=> !tx_user_take [*4])
		else $error("word taken twice within one link cycle");
	AST_RX_HOLD: assert property (
		!rx_freqlocked [*5] |-> rx_digitalreset)
		else $error("receive logic running without frequency lock");
	AST_RX_RELEASE: assert property (
		$fell(rx_digitalreset) |-> $past(rx_freqlocked, 3) && !rx_analogreset)
		else $error("receive reset released without lock");
	AST_COMMA: assert property (
		rx_user_valid |-> rx_user_comma == {comma_of(rx_user_data[39:30]),
		comma_of(rx_user_data[29:20]), comma_of(rx_user_data[19:10]),
		comma_of(rx_user_data[9:0])})
		else $error("comma flags do not match received symbols");
	AST_VALID_PULSE: assert property (
		rx_user_valid |=> !rx_user_valid)
		else $error("receive valid longer than one cycle");
endmodule
bind fcc_top fcc_top_properties u_props (.hclk, .hresetn, .pll_locked,
	.rx_freqlocked, .pll_powerdown, .tx_digitalreset, .rx_analogreset,
	.rx_digitalreset, .rx_cdr_train_pll, .tx_user_ready, .tx_user_take,
	.tx_parallel_data, .rx_user_data, .rx_user_comma, .rx_user_valid);

// file: tb/fcc_xcvr_model.sv
// Behavioural transceiver channel: link clocks, lock flags, receive words
`timescale 1ns/100ps
module fcc_xcvr_model
(
	input  wire logic        pll_powerdown,
	input  wire logic        rx_analogreset,
	input  wire logic        lock_ok,
	input  wire logic        freq_ok,
	input  wire logic [39:0] rx_word,
	output logic             tx_clkout,
	output logic             rx_clkout,
	output logic             pll_locked,
	output logic             rx_freqlocked,
	output logic      [39:0] rx_parallel_data
);
	initial
	begin
		tx_clkout = 1'b0;
		rx_clkout = 1'b0;
		pll_locked = 1'b0;
		rx_freqlocked = 1'b0;
		rx_parallel_data = 40'h0;
		#13;
		forever #40 rx_clkout = ~rx_clkout;
	end
	// A powered-down PLL gives no transmit clock at all
	always #40 tx_clkout = pll_powerdown ? 1'b0 : ~tx_clkout;
	always @(posedge tx_clkout or posedge pll_powerdown)
		if (pll_powerdown)
			pll_locked <= 1'b0;
		else
			pll_locked <= lock_ok;
	// Recovery trains from the PLL reference, so it needs PLL lock
	always @(posedge rx_clkout or posedge rx_analogreset)
		if (rx_analogreset)
			rx_freqlocked <= 1'b0;
		else
			rx_freqlocked <= freq_ok && pll_locked;
	// Held in reset the lines toggle rather than keep the last word
	always @(posedge rx_clkout)
		rx_parallel_data <= rx_analogreset ? ~rx_parallel_data : rx_word;
endmodule

// file: tb/test_fcc_top.sv
// Self-checking bench for one fibre channel coding lane
`timescale 1ns/100ps
`include "fcc_cfg.svh"
module test_fcc_top
	import fcc_pkg::*;
;
	localparam logic [31:0] IDLE = 32'hB5B5B5B5;
	localparam logic [39:0] FILL = {10'h155, 10'h155, 10'h155, 10'h17C};
	localparam logic [39:0] DATA = {10'h0D5, 10'h115, 10'h155, 10'h315};
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        tx_clkout;
	logic [31:0] tx_user_data;
	logic [3:0]  tx_user_k;
	logic        tx_user_eof;
	logic        tx_user_ready;
	logic        tx_user_take;
	logic [39:0] tx_parallel_data;
	logic        rx_clkout;
	logic [39:0] rx_parallel_data;
	logic [39:0] rx_user_data;
	logic [3:0]  rx_user_comma;
	logic        rx_user_valid;
	logic        pll_locked;
	logic        rx_freqlocked;
	logic        pll_powerdown;
	logic        tx_digitalreset;
	logic        rx_analogreset;
	logic        rx_digitalreset;
	logic        rx_cdr_train_pll;
	logic        lock_ok;
	logic        freq_ok;
	logic [39:0] rx_word;
	logic [31:0] rd;
	int          cyc;
	int          t0;
	int          miscompares;
	int          n_compared;
	fcc_top uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .tx_clkout, .tx_user_data, .tx_user_k, .tx_user_eof,
		.tx_user_ready, .tx_user_take, .tx_parallel_data, .rx_clkout,
		.rx_parallel_data, .rx_user_data, .rx_user_comma, .rx_user_valid,
		.pll_locked, .rx_freqlocked, .pll_powerdown, .tx_digitalreset,
		.rx_analogreset, .rx_digitalreset, .rx_cdr_train_pll);
	fcc_xcvr_model u_xcvr (.pll_powerdown, .rx_analogreset, .lock_ok,
		.freq_ok, .rx_word, .tx_clkout, .rx_clkout, .pll_locked,
		.rx_freqlocked, .rx_parallel_data);
	initial hclk = 1'b0;
	always #4 hclk = ~hclk;
	always @(posedge hclk) cyc <= cyc + 1;
	task automatic check(input string nm, input logic [39:0] e,
		input logic [39:0] g);
		n_compared++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
	endtask
	// Word is held until taken, then the neutral idle word returns
	task automatic send(input logic [31:0] d, input logic [3:0] k,
		input logic e, input logic [39:0] x);
		@(posedge hclk);
		tx_user_data <= d;
		tx_user_k <= k;
		tx_user_eof <= e;
		@(posedge hclk);
		#1;
		for (int i = 0; i < 40 && tx_user_take !== 1'b1; i++)
		begin
			@(posedge hclk);
			#1;
		end
		check("tx word", x, tx_parallel_data);
		tx_user_data <= IDLE;
		tx_user_k <= 4'h0;
		tx_user_eof <= 1'b0;
	endtask
	task automatic end_sim();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		#200000;
		miscompares++;
		end_sim();
	end
	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
		{tx_user_data, tx_user_k, tx_user_eof} = {IDLE, 5'h0};
		{lock_ok, freq_ok, rx_word, cyc} = {2'h3, FILL, 32'h0};
		{miscompares, n_compared} = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t0 = cyc;
		ahb(1'b0, `FCC_OFS_CTRL, 32'h0);
		check("ctrl reset", `FCC_CTRL_RST, rd);
		ahb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("state", FCC_RST_PLLPD, rd[6:4]);
		ahb(1'b1, 8'h20, 32'hFFFFFFFF);
		ahb(1'b0, 8'h20, 32'h0);
		check("unmapped", 40'h0, rd);
		ahb(1'b1, `FCC_OFS_CTRL, 32'h19);
		for (int i = 0; i < 300 && pll_powerdown !== 1'b0; i++) @(posedge hclk);
		check("pd span", 1, cyc - t0 >= `FCC_PLL_PD_CYC);
		for (int i = 0; i < 999 && tx_user_ready !== 1'b1; i++) @(posedge hclk);
		ahb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("disparity", 0, rd[2]);
		check("ready lock", 2'h3, {rd[3], rd[0]});
		send(IDLE, 4'h0, 1'b0, {4{10'h155}});
		send(32'hB5B5B5BC, 4'h1, 1'b0, FILL);
		ahb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("disparity", 1, rd[2]);
		send(IDLE, 4'h0, 1'b1, {10'h0D5, 10'h0D5, 10'h155, 10'h283});
		send(IDLE, 4'h0, 1'b1, {10'h0D5, 10'h0D5, 10'h115, 10'h17C});
		for (int i = 0; i < 999 && rx_digitalreset !== 1'b0; i++) @(posedge hclk);
		for (int i = 0; i < 99 && rx_user_valid !== 1'b1; i++) @(posedge hclk);
		#1;
		check("rx fill", FILL, rx_user_data);
		check("rx comma", 4'h1, rx_user_comma);
		rx_word <= DATA;
		for (int i = 0; i < 99 && rx_user_comma[0] !== 1'b0; i++) @(posedge hclk);
		#1;
		check("rx data", DATA, rx_user_data);
		// Equal link clocks: no fill may be added or dropped
		ahb(1'b0, `FCC_OFS_RCCNT, 32'h0);
		check("rc count", 0, rd);
		freq_ok <= 1'b0;
		for (int i = 0; i < 99 && rx_digitalreset !== 1'b1; i++) @(posedge hclk);
		ahb(1'b0, `FCC_OFS_STATUS, 32'h0);
		check("state", FCC_RST_WAIT_CDR, rd[6:4]);
		freq_ok <= 1'b1;
		t0 = cyc;
		for (int i = 0; i < 999 && rx_digitalreset !== 1'b0; i++) @(posedge hclk);
		check("rx delay", 1, cyc - t0 >= `FCC_RX_DLY_CYC);
		lock_ok <= 1'b0;
		for (int i = 0; i < 99 && tx_digitalreset !== 1'b1; i++) @(posedge hclk);
		check("tx ready", 0, tx_user_ready);
		check("rx analog", 1, rx_analogreset);
		lock_ok <= 1'b1;
		for (int i = 0; i < 999 && tx_user_ready !== 1'b1; i++) @(posedge hclk);
		ahb(1'b1, `FCC_OFS_CTRL, 32'h18);
		send(IDLE, 4'h0, 1'b0, {20'h0, 10'h155, 10'h155});
		send(IDLE, 4'h0, 1'b1, {20'h0, 10'h115, 10'h17C});
		repeat (11) @(posedge hclk);
		check("eof tail", {20'h0, 10'h0D5, 10'h0D5}, tx_parallel_data);
		check("tail take", 0, tx_user_take);
		ahb(1'b1, `FCC_OFS_CTRL, 32'h0A);
		repeat (30) @(posedge hclk);
		check("pattern", `FCC_PATTERN, tx_parallel_data);
		check("train", 0, rx_cdr_train_pll);
		ahb(1'b1, `FCC_OFS_CTRL, 32'h0E);
		repeat (2) @(posedge hclk);
		check("restart", 1, pll_powerdown);
		ahb(1'b0, `FCC_OFS_CTRL, 32'h0);
		check("restart clr", 32'h0A, rd);
		end_sim();
	end
endmodule
